// ===== dv/mmu_fault_source.sv
// Purpose: pipeline and lookup side that raises fault events
// Assumes: one request per go pulse, pins held for exactly one cycle
// Notes:   vaddr, pc, r15 and space id pins wander when no event is presented
`timescale 1ns/1ps
`default_nettype none
module mmu_fault_source (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        go,
   input  wire logic [2:0]  kind,
   input  wire logic        hit,
   input  wire logic        dirty,
   input  wire logic [1:0]  prot,
   input  wire logic [31:0] vaddr,
   input  wire logic [31:0] pc,
   input  wire logic [31:0] r15,
   input  wire logic [7:0]  address_space_id,
   output logic             debug_port_reset,
   output logic             instr_multi_match,
   output logic             operand_multi_match,
   output logic             fetch_miss,
   output logic             access_valid,
   output logic             access_write,
   output logic             access_hit,
   output logic             page_dirty,
   output logic [1:0]       protection_field,
   output logic [31:0]      fault_vaddr,
   output logic [31:0]      fault_pc,
   output logic [31:0]      general_reg_fifteen,
   output logic [7:0]       current_address_space_id
);
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         {debug_port_reset, instr_multi_match, operand_multi_match} <= 3'h0;
         {fetch_miss, access_valid, access_write, access_hit, page_dirty} <= 5'h0;
         {protection_field, fault_vaddr, fault_pc, general_reg_fifteen, current_address_space_id} <= '0;
      end else if (go) begin
         debug_port_reset    <= (kind == 3'h1) || (kind == 3'h7);
         instr_multi_match   <= (kind == 3'h2) || (kind == 3'h7);
         operand_multi_match <= (kind == 3'h3);
         fetch_miss          <= (kind == 3'h4);
         access_valid        <= (kind == 3'h5) || (kind == 3'h6);
         access_write        <= (kind == 3'h6);
         access_hit          <= hit;
         page_dirty          <= dirty;
         protection_field    <= prot;
         fault_vaddr         <= vaddr;
         fault_pc            <= pc;
         general_reg_fifteen <= r15;
         current_address_space_id        <= address_space_id;
      end else begin
         {debug_port_reset, instr_multi_match, operand_multi_match} <= 3'h0;
         {fetch_miss, access_valid} <= 2'h0;
         fault_vaddr         <= ~fault_vaddr;
         fault_pc            <= ~fault_pc;
         general_reg_fifteen <= ~general_reg_fifteen;
         current_address_space_id        <= ~current_address_space_id;
      end
   end
endmodule // mmu_fault_source
`default_nettype wire

// ===== dv/reset_and_tlb_exception_entry_tb.sv
// Purpose: random entry events checked against an integer model
// Assumes: random status loads clear the block bit now and then
// Notes:   partner presents events; bench drives vector base loads
`timescale 1ns/1ps
`default_nettype none
module reset_and_tlb_exception_entry_tb;
   logic core_clk, rst_b, go, hit, dirty, vbr_write, vw, dbg, mm, gen, taken;
   logic psw_write, pwe, blk, priv_m, acc, wr, rok, wok, rtype;
   logic [31:0] psw_wdata, pw, exp_psw, exp_pc, exp_fa, exp_page_entry_high_reg, exp_spc, exp_ssr, exp_sgr, offs;
   logic [2:0]  kind;
   logic [1:0]  prot;
   logic [7:0]  address_space_id, current_address_space_id;
   logic [11:0] exp_code, exception_event_code_reg;
   logic [31:0] vaddr, pc, r15, vbr_wdata, vd, exp_vbr, fault_vaddr, fault_pc, general_reg_fifteen;
   logic [31:0] vector_base_reg, processor_status_word, fault_address_reg, page_entry_high_reg;
   logic [31:0] saved_program_counter, saved_status_word, saved_stack_pointer, next_pc;
   logic        debug_port_reset, instr_multi_match, operand_multi_match, fetch_miss, access_valid;
   logic        access_write, access_hit, page_dirty, redirect, manual_init;
   logic [1:0]  protection_field;
   int          num_errors, n_compared, i;
   integer      seed;
   ////////////////////////////////////////////////////////////////////////
   mmu_fault_source partner (.core_clk(core_clk), .rst_b(rst_b), .go(go), .kind(kind), .hit(hit),
      .dirty(dirty), .prot(prot), .vaddr(vaddr), .pc(pc), .r15(r15), .address_space_id(address_space_id),
      .debug_port_reset(debug_port_reset), .instr_multi_match(instr_multi_match),
      .operand_multi_match(operand_multi_match), .fetch_miss(fetch_miss), .access_valid(access_valid),
      .access_write(access_write), .access_hit(access_hit), .page_dirty(page_dirty),
      .protection_field(protection_field), .fault_vaddr(fault_vaddr), .fault_pc(fault_pc),
      .general_reg_fifteen(general_reg_fifteen), .current_address_space_id(current_address_space_id));
   exc_entry uut (.core_clk(core_clk), .rst_b(rst_b), .debug_port_reset(debug_port_reset),
      .instr_multi_match(instr_multi_match), .operand_multi_match(operand_multi_match),
      .fetch_miss(fetch_miss), .access_valid(access_valid), .access_write(access_write),
      .access_hit(access_hit), .page_dirty(page_dirty), .protection_field(protection_field),
      .fault_vaddr(fault_vaddr), .fault_pc(fault_pc), .general_reg_fifteen(general_reg_fifteen),
      .current_address_space_id(current_address_space_id), .vbr_write(vbr_write), .vbr_wdata(vbr_wdata),
      .psw_write(psw_write), .psw_wdata(psw_wdata),
      .exception_event_code_reg(exception_event_code_reg), .vector_base_reg(vector_base_reg),
      .processor_status_word(processor_status_word), .fault_address_reg(fault_address_reg),
      .page_entry_high_reg(page_entry_high_reg), .saved_program_counter(saved_program_counter),
      .saved_status_word(saved_status_word), .saved_stack_pointer(saved_stack_pointer),
      .next_pc(next_pc), .redirect(redirect), .manual_init(manual_init));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (2000) @(posedge core_clk);
      num_errors++;
      report_and_stop;
   end
   initial begin
      seed = 32'hf9cd999f;
      {rst_b, go, kind, hit, dirty, prot, vaddr, pc, r15, address_space_id, vbr_write, vbr_wdata} = '0;
      {psw_write, psw_wdata, exp_fa, exp_page_entry_high_reg, exp_spc, exp_ssr, exp_sgr} = '0;
      exp_vbr = exc_entry_pkg::vector_base_reset;
      exp_psw = exc_entry_pkg::psw_reset;
      exp_pc = exc_entry_pkg::reset_vector;
      exp_code = exc_entry_pkg::code_reset_debug;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      @(negedge core_clk);
      chk(vector_base_reg, exp_vbr);
      chk(processor_status_word, exc_entry_pkg::psw_reset);
      for (i = 0; i < 300; i++) begin
         @(posedge core_clk);
         go    <= 1'b1;
         kind  <= 3'($random(seed));
         {hit, dirty, prot} <= 4'($random(seed));
         vaddr <= $random(seed);
         pc    <= $random(seed);
         r15   <= $random(seed);
         address_space_id  <= 8'($random(seed));
         vw = 1'($random(seed));
         vd = $random(seed);
         pwe = 1'($random(seed));
         pw = $random(seed);
         @(posedge core_clk);
         go        <= 1'b0;
         vbr_write <= vw;
         vbr_wdata <= vd;
         psw_write <= pwe;
         psw_wdata <= pw;
         @(posedge core_clk);
         vbr_write <= 1'b0;
         psw_write <= 1'b0;
         @(negedge core_clk);
         priv_m = exp_psw[exc_entry_pkg::psw_md_pos];
         blk = exp_psw[exc_entry_pkg::psw_bl_pos];
         dbg = (kind == 3'h1) || (kind == 3'h7);
         mm = (kind == 3'h2) || (kind == 3'h3) || (kind == 3'h7);
         acc = (kind == 3'h5) || (kind == 3'h6);
         wr = (kind == 3'h6);
         rok = prot[1] || priv_m;
         wok = (prot == 2'h3) || (prot == 2'h1 && priv_m);
         gen = (kind == 3'h4) || (acc && (!hit || (!wr && !rok) || (wr && (!wok || !dirty))));
         rtype = dbg || mm || (gen && blk);
         taken = rtype || gen;
         offs = exc_entry_pkg::general_offset;
         if (dbg) begin
            exp_code = exc_entry_pkg::code_reset_debug;
         end else if (mm) begin
            exp_code = exc_entry_pkg::code_multi_match;
         end else if (rtype) begin
            exp_code = exc_entry_pkg::code_manual_reset;
         end else if (kind == 3'h4 || (acc && !hit)) begin
            exp_code = wr ? exc_entry_pkg::code_write_miss : exc_entry_pkg::code_read_miss;
            offs = exc_entry_pkg::miss_offset;
         end else if (acc && !wr && !rok) begin
            exp_code = exc_entry_pkg::code_read_prot;
         end else if (acc && wr && !wok) begin
            exp_code = exc_entry_pkg::code_write_prot;
         end else if (gen) begin
            exp_code = exc_entry_pkg::code_first_write;
         end
         if ((mm && !dbg) || (gen && !rtype)) begin
            exp_fa = vaddr;
            exp_page_entry_high_reg = {vaddr[31:10], 2'h0, address_space_id};
         end
         if (rtype) begin
            exp_vbr = exc_entry_pkg::vector_base_reset;
            exp_psw = exp_psw | exc_entry_pkg::psw_reset;
            exp_psw[exc_entry_pkg::psw_fd_pos] = 1'b0;
            exp_pc = exc_entry_pkg::reset_vector;
         end else if (gen) begin
            exp_pc = exp_vbr + offs;
            exp_spc = pc;
            exp_ssr = exp_psw;
            exp_sgr = r15;
            exp_psw[exc_entry_pkg::psw_md_pos] = 1'b1;
            exp_psw[exc_entry_pkg::psw_rb_pos] = 1'b1;
            exp_psw[exc_entry_pkg::psw_bl_pos] = 1'b1;
         end else begin
            if (vw) begin
               exp_vbr = vd;
            end
            if (pwe) begin
               exp_psw = pw;
            end
         end
         chk({20'h0, exception_event_code_reg}, {20'h0, exp_code});
         chk(vector_base_reg, exp_vbr);
         chk(processor_status_word, exp_psw);
         chk(next_pc, exp_pc);
         chk({31'h0, redirect}, {31'h0, taken});
         chk({31'h0, manual_init}, {31'h0, rtype && !dbg});
         chk(fault_address_reg, exp_fa);
         chk(page_entry_high_reg, exp_page_entry_high_reg);
         chk(saved_program_counter, exp_spc);
         chk(saved_status_word, exp_ssr);
         chk(saved_stack_pointer, exp_sgr);
      end
      report_and_stop;
   end
endmodule // reset_and_tlb_exception_entry_tb
`default_nettype wire

// ===== hdl/exc_entry.sv
// Purpose: reset-type and translation exception entry for the core
// Assumes: pipeline presents one access per cycle with its lookup result
// Notes:   all outputs registered; one entry taken per cycle
//
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - debug-port reset writes code 000 and jumps to the reset vector
// - reset entries zero vector base, set md/rb/bl, clear fd, mask to F
// - instruction buffer multiple match takes reset entry with code 140
// - unified buffer multiple match takes reset entry with code 140
// - multiple match resets request manual-style initialisation, not power-on
// - capture fault address and its page number into page entry high
// - page entry high keeps the current address space id
// - general entries save pc, status word and register fifteen
// - general entries set block, privilege and bank bits
// - read miss writes code 040, jumps to vector base plus 400
// - write miss writes code 060, jumps to vector base plus 400
// - fetch miss writes code 040, jumps to vector base plus 400
// - all misses use offset 400, distinct from general offset 100
// - store to clean page writes code 080, jumps to base plus 100
// - protection field decides read and write rights per mode
// - read protection fault writes code 0A0, base plus 100
// - write protection fault writes code 0C0, base plus 100
// - general fault while blocked becomes manual reset to reset vector
module exc_entry (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        debug_port_reset,
   input  wire logic        instr_multi_match,
   input  wire logic        operand_multi_match,
   input  wire logic        fetch_miss,
   input  wire logic        access_valid,
   input  wire logic        access_write,
   input  wire logic        access_hit,
   input  wire logic        page_dirty,
   input  wire logic [1:0]  protection_field,
   input  wire logic [31:0] fault_vaddr,
   input  wire logic [31:0] fault_pc,
   input  wire logic [31:0] general_reg_fifteen,
   input  wire logic [7:0]  current_address_space_id,
   input  wire logic        vbr_write,
   input  wire logic [31:0] vbr_wdata,
   input  wire logic        psw_write,
   input  wire logic [31:0] psw_wdata,
   output logic [11:0]      exception_event_code_reg,
   output logic [31:0]      vector_base_reg,
   output logic [31:0]      processor_status_word,
   output logic [31:0]      fault_address_reg,
   output logic [31:0]      page_entry_high_reg,
   output logic [31:0]      saved_program_counter,
   output logic [31:0]      saved_status_word,
   output logic [31:0]      saved_stack_pointer,
   output logic [31:0]      next_pc,
   output logic             redirect,
   output logic             manual_init
);

   typedef enum logic [3:0] {
      kind_none  = 4'h1,
      kind_reset = 4'h2,
      kind_gen   = 4'h4,
      kind_man   = 4'h8
   } kind_type;

   ////////////////////////////////////////////////////////////////////////////
   // event decode
   logic       priv;
   logic       read_ok;
   logic       write_ok;
   logic       read_miss;
   logic       write_miss;
   logic       clean_store;
   logic       read_prot;
   logic       write_prot;
   logic       multi;
   logic       general;
   logic       blocked;
   kind_type   kind;
   logic [11:0] code;
   logic [31:0] offset;

   assign priv    = processor_status_word[exc_entry_pkg::psw_md_pos];
   assign blocked = processor_status_word[exc_entry_pkg::psw_bl_pos];

   always_comb begin
      case (protection_field)
         exc_entry_pkg::prot_priv_ro: begin
            read_ok  = priv;
            write_ok = 1'b0;
         end
         exc_entry_pkg::prot_priv_rw: begin
            read_ok  = priv;
            write_ok = priv;
         end
         exc_entry_pkg::prot_all_ro: begin
            read_ok  = 1'b1;
            write_ok = 1'b0;
         end
         default: begin
            read_ok  = 1'b1;
            write_ok = 1'b1;
         end
      endcase
   end

   assign read_miss   = access_valid && !access_hit && !access_write;
   assign write_miss  = access_valid && !access_hit && access_write;
   assign read_prot   = access_valid && access_hit && !access_write && !read_ok;
   assign write_prot  = access_valid && access_hit && access_write && !write_ok;
   assign clean_store = access_valid && access_hit && access_write && write_ok && !page_dirty;
   assign multi       = instr_multi_match || operand_multi_match;
   assign general     = fetch_miss || read_miss || write_miss || read_prot || write_prot || clean_store;

   always_comb begin
      kind   = kind_none;
      code   = exc_entry_pkg::code_reset_debug;
      offset = exc_entry_pkg::general_offset;
      if (debug_port_reset) begin
         kind = kind_reset;
      end else if (multi) begin
         kind = kind_man;
         code = exc_entry_pkg::code_multi_match;
      end else if (general && blocked) begin
         kind = kind_man;
         code = exc_entry_pkg::code_manual_reset;
      end else if (fetch_miss) begin
         kind   = kind_gen;
         code   = exc_entry_pkg::code_read_miss;
         offset = exc_entry_pkg::miss_offset;
      end else if (read_miss) begin
         kind   = kind_gen;
         code   = exc_entry_pkg::code_read_miss;
         offset = exc_entry_pkg::miss_offset;
      end else if (write_miss) begin
         kind   = kind_gen;
         code   = exc_entry_pkg::code_write_miss;
         offset = exc_entry_pkg::miss_offset;
      end else if (read_prot) begin
         kind = kind_gen;
         code = exc_entry_pkg::code_read_prot;
      end else if (write_prot) begin
         kind = kind_gen;
         code = exc_entry_pkg::code_write_prot;
      end else if (clean_store) begin
         kind = kind_gen;
         code = exc_entry_pkg::code_first_write;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // code, redirect and target
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         exception_event_code_reg <= exc_entry_pkg::code_reset_debug;
         next_pc                  <= exc_entry_pkg::reset_vector;
         redirect                 <= 1'b0;
         manual_init              <= 1'b0;
      end else begin
         redirect    <= (kind != kind_none);
         manual_init <= (kind == kind_man);
         if (kind != kind_none) begin
            exception_event_code_reg <= code;
         end
         if (kind == kind_gen) begin
            next_pc <= vector_base_reg + offset;
         end else if (kind != kind_none) begin
            next_pc <= exc_entry_pkg::reset_vector;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // vector base
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vector_base_reg <= exc_entry_pkg::vector_base_reset;
      end else if (kind == kind_reset || kind == kind_man) begin
         vector_base_reg <= exc_entry_pkg::vector_base_reset;
      end else if (vbr_write && kind == kind_none) begin
         vector_base_reg <= vbr_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         processor_status_word <= exc_entry_pkg::psw_reset;
      end else if (kind == kind_reset || kind == kind_man) begin
         processor_status_word[exc_entry_pkg::psw_md_pos] <= 1'b1;
         processor_status_word[exc_entry_pkg::psw_rb_pos] <= 1'b1;
         processor_status_word[exc_entry_pkg::psw_bl_pos] <= 1'b1;
         processor_status_word[exc_entry_pkg::psw_fd_pos] <= 1'b0;
         processor_status_word[exc_entry_pkg::psw_imask_hi:exc_entry_pkg::psw_imask_lo] <=
            exc_entry_pkg::imask_reset;
      end else if (kind == kind_gen) begin
         processor_status_word[exc_entry_pkg::psw_md_pos] <= 1'b1;
         processor_status_word[exc_entry_pkg::psw_rb_pos] <= 1'b1;
         processor_status_word[exc_entry_pkg::psw_bl_pos] <= 1'b1;
      end else if (psw_write && kind == kind_none) begin
         processor_status_word <= psw_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault capture
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_address_reg   <= '0;
         page_entry_high_reg <= '0;
      end else if (kind == kind_gen || (kind == kind_man && multi)) begin
         fault_address_reg <= fault_vaddr;
         page_entry_high_reg <= {fault_vaddr[31:exc_entry_pkg::vpn_lo], 2'h0,
                                 current_address_space_id};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // saved context
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         saved_program_counter <= '0;
         saved_status_word     <= '0;
         saved_stack_pointer   <= '0;
      end else if (kind == kind_gen) begin
         saved_program_counter <= fault_pc;
         saved_status_word     <= processor_status_word;
         saved_stack_pointer   <= general_reg_fifteen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks: reset-type entries
   a_debug_reset: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      debug_port_reset |=> exception_event_code_reg == exc_entry_pkg::code_reset_debug
      && next_pc == exc_entry_pkg::reset_vector && redirect)
      else $error("debug reset entry wrong");
   a_reset_status: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_reset || kind == kind_man) |=> vector_base_reg == exc_entry_pkg::vector_base_reset
      && processor_status_word[exc_entry_pkg::psw_fd_pos] == 1'b0
      && processor_status_word[exc_entry_pkg::psw_imask_hi:exc_entry_pkg::psw_imask_lo] == exc_entry_pkg::imask_reset)
      else $error("reset status wrong");
   a_reset_bits: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_reset || kind == kind_man) |=> processor_status_word[exc_entry_pkg::psw_md_pos]
      && processor_status_word[exc_entry_pkg::psw_rb_pos] && processor_status_word[exc_entry_pkg::psw_bl_pos])
      else $error("reset status bits wrong");
   a_multi_code: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (instr_multi_match && !debug_port_reset) |=>
      exception_event_code_reg == exc_entry_pkg::code_multi_match && next_pc == exc_entry_pkg::reset_vector)
      else $error("instruction multi match wrong");
   a_operand_multi: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (operand_multi_match && !debug_port_reset) |=>
      exception_event_code_reg == exc_entry_pkg::code_multi_match && next_pc == exc_entry_pkg::reset_vector)
      else $error("operand multi match wrong");
   a_manual_init: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (multi && !debug_port_reset) |=>
      manual_init && redirect)
      else $error("multi match not manual style");
   a_blocked_fault: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (general && blocked && !multi && !debug_port_reset) |=>
      exception_event_code_reg == exc_entry_pkg::code_manual_reset && next_pc == exc_entry_pkg::reset_vector)
      else $error("blocked fault not reset");

   ////////////////////////////////////////////////////////////////////////////
   // checks: capture and context
   a_fault_capture: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen) |=> fault_address_reg == $past(fault_vaddr)
      && page_entry_high_reg[31:exc_entry_pkg::vpn_lo] == $past(fault_vaddr[31:exc_entry_pkg::vpn_lo]))
      else $error("fault capture wrong");
   a_address_space_id_capture: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen) |=>
      page_entry_high_reg[exc_entry_pkg::address_space_id_hi:0] == $past(current_address_space_id))
      else $error("address_space_id capture wrong");
   a_context_save: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen) |=> saved_status_word == $past(processor_status_word)
      && saved_stack_pointer == $past(general_reg_fifteen) && saved_program_counter == $past(fault_pc))
      else $error("context save wrong");
   a_status_set: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen) |=> processor_status_word[exc_entry_pkg::psw_md_pos]
      && processor_status_word[exc_entry_pkg::psw_rb_pos] && processor_status_word[exc_entry_pkg::psw_bl_pos])
      else $error("general status bits wrong");
   a_general_keep: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen) |=> $stable(vector_base_reg)
      && $stable(processor_status_word[exc_entry_pkg::psw_fd_pos])
      && $stable(processor_status_word[exc_entry_pkg::psw_imask_hi:exc_entry_pkg::psw_imask_lo]))
      else $error("general entry altered base");

   ////////////////////////////////////////////////////////////////////////////
   // checks: general codes and targets
   a_miss_target: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && offset == exc_entry_pkg::miss_offset) |=>
      next_pc == $past(vector_base_reg) + exc_entry_pkg::miss_offset && redirect)
      else $error("miss target wrong");
   a_other_target: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && offset == exc_entry_pkg::general_offset) |=>
      next_pc == $past(vector_base_reg) + exc_entry_pkg::general_offset && redirect)
      else $error("general target wrong");
   a_read_miss: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && read_miss && !fetch_miss) |=>
      exception_event_code_reg == exc_entry_pkg::code_read_miss)
      else $error("read miss code wrong");
   a_write_miss: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && write_miss && !fetch_miss) |=>
      exception_event_code_reg == exc_entry_pkg::code_write_miss)
      else $error("write miss code wrong");
   a_fetch_miss: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && fetch_miss) |=>
      exception_event_code_reg == exc_entry_pkg::code_read_miss)
      else $error("fetch miss code wrong");
   a_clean_store: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && clean_store && !fetch_miss) |=>
      exception_event_code_reg == exc_entry_pkg::code_first_write)
      else $error("clean store code wrong");
   a_user_write: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!priv && !blocked && access_valid && access_hit && access_write && !fetch_miss && !multi
      && !debug_port_reset && protection_field == exc_entry_pkg::prot_priv_rw) |=>
      exception_event_code_reg == exc_entry_pkg::code_write_prot)
      else $error("user write not refused");
   a_read_prot: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && read_prot && !fetch_miss) |=>
      exception_event_code_reg == exc_entry_pkg::code_read_prot)
      else $error("read prot code wrong");
   a_write_prot: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (kind == kind_gen && write_prot && !fetch_miss) |=>
      exception_event_code_reg == exc_entry_pkg::code_write_prot)
      else $error("write prot code wrong");
endmodule // exc_entry
`default_nettype wire

// ===== hdl/exc_entry_pkg.sv
// Purpose: constants for the reset and translation exception entry unit
// Assumes: 32-bit addresses, core clock domain only
// Notes:   codes, vectors and status bit positions
package exc_entry_pkg;
   localparam logic [11:0] code_reset_debug  = 12'h000;
   localparam logic [11:0] code_manual_reset = 12'h020;
   localparam logic [11:0] code_multi_match  = 12'h140;
   localparam logic [11:0] code_read_miss    = 12'h040;
   localparam logic [11:0] code_write_miss   = 12'h060;
   localparam logic [11:0] code_first_write  = 12'h080;
   localparam logic [11:0] code_read_prot    = 12'h0A0;
   localparam logic [11:0] code_write_prot   = 12'h0C0;
   localparam logic [31:0] reset_vector      = 32'hA000_0000;
   localparam logic [31:0] vector_base_reset = 32'h0000_0000;
   localparam logic [31:0] miss_offset       = 32'h0000_0400;
   localparam logic [31:0] general_offset    = 32'h0000_0100;
   localparam logic [3:0]  imask_reset       = 4'hF;
   localparam int          psw_md_pos        = 30;
   localparam int          psw_rb_pos        = 29;
   localparam int          psw_bl_pos        = 28;
   localparam int          psw_fd_pos        = 15;
   localparam int          psw_imask_lo      = 4;
   localparam int          psw_imask_hi      = 7;
   localparam int          vpn_lo            = 10;
   localparam int          address_space_id_hi           = 7;
   localparam logic [1:0]  prot_priv_ro      = 2'h0;
   localparam logic [1:0]  prot_priv_rw      = 2'h1;
   localparam logic [1:0]  prot_all_ro       = 2'h2;
   localparam logic [1:0]  prot_all_rw       = 2'h3;
   localparam logic [31:0] psw_reset         = 32'h7000_00F0;
endpackage
